// ===== cycle_timer_and_link_events_test.sv
// Self-checking bench for the cycle timer block, driven through the host model.
// Assumes a 50 ns pclk; each long run lasts just over one 2500-cycle (125 us) period.
`timescale 1ns/1ns
`include "cytm_defs.svh"

module cycle_timer_and_link_events_test;
  import cytm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, cycle_master, irq_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  cytm_evt_t evt = '0;
  cytm_evt_t ev [5] = '{6'h20, 6'h10, 6'h08, 6'h02, 6'h01};
  int mismatches = 0;
  int samples_checked = 0;
  always #25 pclk = ~pclk;
  cytm_events dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .cycle_master(cycle_master), .irq_n(irq_n));
  cytm_host_model host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    host_u.rd(a, q);
    check(q & m, exp);
  endtask
  task automatic pulse(input cytm_evt_t v);
    @(posedge pclk);
    evt <= v;
    @(posedge pclk);
    evt <= '0;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  // A hang costs one mismatch; the full run needs about 5300 cycles.
  initial begin
    repeat (12000) @(posedge pclk);
    mismatches++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`CYTM_OFS_IEN, 32'hFFFFFFFF, 32'h00000000);
    check({31'h0, pslverr}, 32'h00000000);
    rchk(`CYTM_OFS_TIME, 32'hFFFFFFFF, 32'h00000000);
    rchk(`CYTM_OFS_STAT, 32'hFFFFFFFF, 32'h00000000);
    host_u.wr(`CYTM_OFS_IEN, 32'hFFFFFFFF);
    rchk(`CYTM_OFS_IEN, 32'hFFFFFFFF, 32'h003FFFFF);
    host_u.wr(`CYTM_OFS_IEN, 32'h00000000);
    host_u.wr(12'h020, 32'hFFFFFFFF);
    rchk(12'h020, 32'hFFFFFFFF, 32'h00000000);
    check({31'h0, pslverr}, 32'h00000001);
    host_u.wr(`CYTM_OFS_TIME, 32'h12345678);
    repeat (20) @(posedge pclk);
    rchk(`CYTM_OFS_TIME, 32'hFFFFFFFF, 32'h12345678);
    foreach (ev[i]) pulse(ev[i]);
    rchk(`CYTM_OFS_STAT, 32'hFFFFFFFF, 32'h000001CC);
    check({31'h0, irq_n}, 32'h00000001);
    host_u.wr(`CYTM_OFS_STAT, 32'h00000000);
    rchk(`CYTM_OFS_STAT, 32'hFFFFFFFF, 32'h000001CC);
    host_u.wr(`CYTM_OFS_STAT, 32'h00000004);
    rchk(`CYTM_OFS_STAT, 32'hFFFFFFFF, 32'h000001C8);
    host_u.wr(`CYTM_OFS_IEN, 32'h00000100);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_n}, 32'h00000000);
    host_u.wr(`CYTM_OFS_STAT, 32'h000001FF);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_n}, 32'h00000001);
    host_u.wr(`CYTM_OFS_TIME, 32'h00000BF0);
    host_u.wr(`CYTM_OFS_CTRL, 32'h00000001);
    repeat (30) @(posedge pclk);
    host_u.wr(`CYTM_OFS_CTRL, 32'h00000000);
    rchk(`CYTM_OFS_TIME, 32'hFFFFF000, 32'h00001000);
    rchk(`CYTM_OFS_STAT, 32'h00000003, 32'h00000002);
    host_u.wr(`CYTM_OFS_STAT, 32'h00000002);
    rchk(`CYTM_OFS_STAT, 32'h00000003, 32'h00000002);
    host_u.wr(`CYTM_OFS_TIME, 32'h01F3FBF0);
    host_u.wr(`CYTM_OFS_CTRL, 32'h00000001);
    repeat (30) @(posedge pclk);
    host_u.wr(`CYTM_OFS_CTRL, 32'h00000000);
    rchk(`CYTM_OFS_TIME, 32'hFFFFF000, 32'h02000000);
    rchk(`CYTM_OFS_STAT, 32'h00000013, 32'h00000013);
    host_u.wr(`CYTM_OFS_STAT, 32'h000001FF);
    host_u.wr(`CYTM_OFS_TIME, 32'h00000BF0);
    host_u.wr(`CYTM_OFS_CTRL, 32'h00000003);
    repeat (2600) @(posedge pclk);
    host_u.wr(`CYTM_OFS_CTRL, 32'h00000002);
    rchk(`CYTM_OFS_STAT, 32'h00000001, 32'h00000000);
    check({31'h0, cycle_master}, 32'h00000001);
    host_u.wr(`CYTM_OFS_STAT, 32'h000001FF);
    pulse(6'h04);
    repeat (2510) @(posedge pclk);
    rchk(`CYTM_OFS_STAT, 32'h00000028, 32'h00000028);
    check({31'h0, cycle_master}, 32'h00000000);
    final_report;
  end
endmodule // cycle_timer_and_link_events_test

// ===== cytm_defs.svh
// Register offsets, field positions, reset values and timing counts of the cycle timer block.
// Assumes a 20 MHz pclk and an APB master with 32-bit data.
// Functional notes
// RULE1: Busy acknowledge sent because receive FIFO overflowed sets status bit 8.
// RULE2: Header CRC error on a possibly addressed packet sets status bit 7.
// RULE3: Invalid transaction code seen by transmitter sets status bit 6.
// RULE4: Cycle longer than 125 us sets bit 5 and drops cycle master.
// RULE5: Every seconds field increment sets status bit 4.
// RULE6: Cycle start packet sent or received sets status bit 3.
// RULE7: Fair gap after a cycle start sets status bit 2.
// RULE8: Writing zero to the cycle done bit changes nothing.
// RULE9: Cycle pending rises when offset becomes zero, holds until cycle ends.
// RULE10: Two rollovers without received cycle start set status bit 0.
// RULE11: Cycle lost is never set while acting as cycle master.
// RULE12: Enable register mirrors status register bit for bit.
// RULE13: Enable one passes status to interrupt; zero blocks, status still set.
// RULE14: Enable bits 21 to 0, all cleared at reset.
// RULE15: Cycle timer counts only while the count enable bit is set.
// RULE16: Disabled cycle timer is plain read/write storage.
// RULE17: Offset field 11..0 counts at 24.576 MHz, host writable.
// RULE18: Cycle number field 24..12 counts at 8 kHz, host writable.
// RULE19: Seconds field 31..25 counts at 1 Hz, host writable.
// RULE20: Host writes one to a status bit to clear it; here bit 1 ignores status writes and clears at cycle end.
// RULE21: Interrupt stays active while any enabled status bit is set.
// RULE22: Offset wraps at 3071, cycle number at 7999, each carrying upward.
`ifndef CYTM_DEFS_SVH
`define CYTM_DEFS_SVH

`define CYTM_OFS_CTRL 12'h004
`define CYTM_OFS_STAT 12'h008
`define CYTM_OFS_IEN 12'h00C
`define CYTM_OFS_TIME 12'h010

`define CYTM_CTRL_CNT_EN 0
`define CYTM_CTRL_MASTER 1
`define CYTM_CTRL_RST 2'h0

`define CYTM_BIT_BUSY 8
`define CYTM_BIT_HDR 7
`define CYTM_BIT_TCODE 6
`define CYTM_BIT_OVR 5
`define CYTM_BIT_SEC 4
`define CYTM_BIT_BEGAN 3
`define CYTM_BIT_DONE 2
`define CYTM_BIT_WAIT 1
`define CYTM_BIT_MISS 0
`define CYTM_STAT_W 9
`define CYTM_STAT_RST 9'h000
`define CYTM_IEN_W 22
`define CYTM_IEN_RST 22'h000000
`define CYTM_TIME_RST 32'h00000000

`define CYTM_OFF_LSB 0
`define CYTM_NUM_LSB 12
`define CYTM_SEC_LSB 25
`define CYTM_OFF_MAX 12'd3071
`define CYTM_NUM_MAX 13'd7999

`define CYTM_CLK_KHZ 20000
`define CYTM_TICK_KHZ 24576
`define CYTM_CLK_NS 50
`define CYTM_OVR_NS 125000
`define CYTM_OVR_CYC (`CYTM_OVR_NS / `CYTM_CLK_NS)

`endif

// ===== cytm_events.sv
// Cycle timer, cycle and packet event status, and interrupt enable, behind an APB slave.
// Assumes event strobes are one-cycle pulses on pclk from the link logic.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "cytm_defs.svh"

module cytm_events (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cytm_pkg::cytm_evt_t evt,
  output logic cycle_master,
  output logic irq_n
);
  import cytm_pkg::*;

  // ********************************
  // Bus decode
  // ********************************
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [1:0] ctrl_r;
  logic [`CYTM_STAT_W-1:0] stat_r;
  logic [`CYTM_IEN_W-1:0] ien_r;
  cytm_time_t time_r;
  logic irq_n_r;

  wire logic sel_ctrl;
  wire logic sel_stat;
  wire logic sel_ien;
  wire logic sel_time;
  wire logic mapped;
  wire logic acc_done;
  wire logic wr_en;
  wire logic setup;
  wire logic [31:0] rd_val;

  // One compare serves every register select, so all offsets decode alike.
  function automatic logic ofs_hit(input logic [11:0] addr, input logic [11:0] ofs);
    return (addr == ofs);
  endfunction

  assign sel_ctrl = ofs_hit(paddr, `CYTM_OFS_CTRL);
  assign sel_stat = ofs_hit(paddr, `CYTM_OFS_STAT);
  assign sel_ien = ofs_hit(paddr, `CYTM_OFS_IEN);
  assign sel_time = ofs_hit(paddr, `CYTM_OFS_TIME);
  assign mapped = sel_ctrl | sel_stat | sel_ien | sel_time;
  assign setup = psel & ~penable & ~pready_r;
  assign acc_done = psel & penable & pready_r;
  assign wr_en = acc_done & pwrite & mapped;

  assign rd_val = sel_ctrl ? {30'h0, ctrl_r} :
                  sel_stat ? {23'h0, stat_r} :
                  sel_ien ? {10'h0, ien_r} :
                  sel_time ? time_r : 32'h00000000;

  wire logic pready_nxt;
  wire logic pslverr_nxt;
  wire logic [31:0] prdata_nxt;

  // The answer comes one cycle after setup, so pready is always a flop.
  assign pready_nxt = setup;
  assign pslverr_nxt = setup & ~mapped;
  // Read data is zero outside the answer cycle, so a stale word never stays on the bus.
  assign prdata_nxt = (setup & ~pwrite) ? rd_val : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= pslverr_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // ********************************
  // Control register
  // ********************************
  wire logic cnt_en;
  wire logic ovr_evt;
  wire logic [1:0] ctrl_nxt;

  assign cnt_en = ctrl_r[`CYTM_CTRL_CNT_EN];
  // RULE4: overrun drops master.
  // The hardware drop wins over a host set in the same cycle, so a bad cycle always ends mastering.
  assign ctrl_nxt[`CYTM_CTRL_CNT_EN] = (wr_en & sel_ctrl) ? pwdata[`CYTM_CTRL_CNT_EN] : cnt_en;
  assign ctrl_nxt[`CYTM_CTRL_MASTER] = ~ovr_evt &
    ((wr_en & sel_ctrl) ? pwdata[`CYTM_CTRL_MASTER] : ctrl_r[`CYTM_CTRL_MASTER]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CYTM_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ********************************
  // Cycle timer
  // ********************************
  // The offset ticks at 24.576 MHz from a 20 MHz clock, so a phase accumulator
  // advances it by one or two per clock; the average rate is exact.
  logic [15:0] phase_r;
  wire logic [15:0] phase_sum;
  wire logic two_step;
  wire logic [15:0] phase_nxt;
  wire logic [12:0] off_sum;
  wire logic off_wrap;
  wire logic [11:0] off_cnt;
  wire logic num_wrap;
  wire logic [12:0] num_cnt;
  wire logic [6:0] sec_cnt;
  wire logic sec_inc;
  wire logic roll;
  wire logic host_zero;
  wire logic time_wr;
  cytm_time_t time_nxt;

  assign phase_sum = phase_r + 16'(`CYTM_TICK_KHZ - `CYTM_CLK_KHZ);
  assign two_step = (phase_sum >= 16'(`CYTM_CLK_KHZ));
  assign phase_nxt = two_step ? (phase_sum - 16'(`CYTM_CLK_KHZ)) : phase_sum;

  // RULE17: offset rate.
  assign off_sum = {1'b0, time_r.offset} + (two_step ? 13'd2 : 13'd1);
  // RULE22: wrap and carry.
  assign off_wrap = (off_sum > {1'b0, `CYTM_OFF_MAX});
  assign off_cnt = off_wrap ? 12'(off_sum - 13'd3072) : off_sum[11:0];
  assign num_wrap = off_wrap & (time_r.number == `CYTM_NUM_MAX);
  // RULE18: cycle number rate.
  assign num_cnt = num_wrap ? 13'd0 : (off_wrap ? time_r.number + 13'd1 : time_r.number);
  // RULE19: seconds rate.
  assign sec_cnt = num_wrap ? time_r.seconds + 7'd1 : time_r.seconds;

  // A host write replaces the count, so no carry event is raised in that cycle.
  assign time_wr = wr_en & sel_time;
  // RULE15: counting gated.
  assign roll = cnt_en & off_wrap & ~time_wr;
  assign sec_inc = cnt_en & num_wrap & ~time_wr;
  assign host_zero = time_wr & (pwdata[11:0] == 12'h000);

  // RULE16: plain storage.
  // A host write wins over counting; otherwise the timer holds while disabled.
  always_comb begin
    time_nxt = time_r;
    if (wr_en & sel_time) begin
      time_nxt = pwdata;
    end else if (cnt_en) begin
      time_nxt.offset = off_cnt;
      time_nxt.number = num_cnt;
      time_nxt.seconds = sec_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_r <= `CYTM_TIME_RST;
    end else begin
      time_r <= time_nxt;
    end
  end

  // The accumulator only moves while counting, so a paused timer resumes at the same phase.
  // It restarts only at reset; a host write to the timer does not realign it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 16'h0000;
    end else begin
      phase_r <= cnt_en ? phase_nxt : phase_r;
    end
  end

  // ********************************
  // Cycle tracking
  // ********************************
  cytm_phase_t phase_st_r;
  cytm_phase_t phase_st_nxt;
  logic [11:0] ovr_cnt_r;
  logic ovr_seen_r;
  logic miss_cnt_r;
  wire logic cyc_start;
  wire logic cyc_end;

  assign cyc_start = evt.cycle_start_tx | evt.cycle_start_rx;
  assign cyc_end = (phase_st_r == CYTM_RUN) & evt.fair_gap;
  // RULE4: timeout detect.
  assign ovr_evt = (phase_st_r == CYTM_RUN) & ~ovr_seen_r &
                   (ovr_cnt_r == 12'(`CYTM_OVR_CYC));

  always_comb begin
    phase_st_nxt = phase_st_r;
    unique case (phase_st_r)
      CYTM_IDLE: begin
        if (cyc_start) begin
          phase_st_nxt = CYTM_RUN;
        end
      end
      CYTM_RUN: begin
        if (evt.fair_gap) begin
          phase_st_nxt = CYTM_IDLE;
        end
      end
    endcase
  end

  wire logic [11:0] ovr_cnt_nxt;
  wire logic ovr_seen_nxt;
  wire logic ovr_run;

  // The length count only runs inside a cycle and stops once an overrun is flagged,
  // so a stuck cycle raises the overrun event exactly once.
  assign ovr_run = (phase_st_nxt == CYTM_RUN) & (phase_st_r == CYTM_RUN) & ~ovr_seen_r;
  assign ovr_cnt_nxt = ovr_run ? (ovr_cnt_r + 12'h001) :
                       ((phase_st_r == CYTM_RUN) ? ovr_cnt_r : 12'h000);
  assign ovr_seen_nxt = (phase_st_nxt == CYTM_RUN) & (ovr_seen_r | ovr_evt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_st_r <= CYTM_IDLE;
    end else begin
      phase_st_r <= phase_st_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_cnt_r <= 12'h000;
    end else begin
      ovr_cnt_r <= ovr_cnt_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_seen_r <= 1'b0;
    end else begin
      ovr_seen_r <= ovr_seen_nxt;
    end
  end

  // RULE10: rollover pairing.
  // One pending rollover is remembered; a received cycle start forgets it.
  wire logic miss_evt;
  // RULE11: master blocks loss.
  assign miss_evt = roll & miss_cnt_r & ~ctrl_r[`CYTM_CTRL_MASTER] & ~evt.cycle_start_rx;

  wire logic miss_cnt_nxt;

  // A received start beats a rollover in the same cycle, since the start proves the bus alive.
  assign miss_cnt_nxt = ~evt.cycle_start_rx & (miss_cnt_r | roll);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_cnt_r <= 1'b0;
    end else begin
      miss_cnt_r <= miss_cnt_nxt;
    end
  end

  // ********************************
  // Event status
  // ********************************
  logic [`CYTM_STAT_W-1:0] set_v;
  logic [`CYTM_STAT_W-1:0] clr_v;
  logic [`CYTM_STAT_W-1:0] stat_nxt;

  always_comb begin
    set_v = '0;
    // RULE1: busy acknowledge.
    set_v[`CYTM_BIT_BUSY] = evt.busy_ack_sent;
    // RULE2: header CRC.
    set_v[`CYTM_BIT_HDR] = evt.header_crc_error;
    // RULE3: transaction code.
    set_v[`CYTM_BIT_TCODE] = evt.bad_transaction_code;
    set_v[`CYTM_BIT_OVR] = ovr_evt;
    // RULE5: seconds tick.
    set_v[`CYTM_BIT_SEC] = sec_inc;
    // RULE6: cycle began.
    set_v[`CYTM_BIT_BEGAN] = cyc_start;
    // RULE7: cycle finished.
    set_v[`CYTM_BIT_DONE] = cyc_end;
    // RULE9: offset at zero.
    set_v[`CYTM_BIT_WAIT] = roll | host_zero;
    // RULE10: cycle missing.
    set_v[`CYTM_BIT_MISS] = miss_evt;
  end

  // RULE20: write one clears.
  // RULE8: zero has no effect.
  always_comb begin
    clr_v = (wr_en & sel_stat) ? pwdata[`CYTM_STAT_W-1:0] : '0;
    // RULE9: held until cycle end.
    // The pending flag clears with the cycle, not the host, so status writes leave it alone.
    clr_v[`CYTM_BIT_WAIT] = cyc_end;
  end

  // A set in the same cycle as its clear wins, so no event is lost.
  genvar gi;
  generate
    for (gi = 0; gi < `CYTM_STAT_W; gi = gi + 1) begin : g_stat
      assign stat_nxt[gi] = set_v[gi] | (stat_r[gi] & ~clr_v[gi]);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= `CYTM_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ********************************
  // Interrupt enable and output
  // ********************************
  wire logic irq_nxt;

  // RULE12: mirrored layout.
  // RULE13: enable gates interrupt.
  assign irq_nxt = |(stat_r & ien_r[`CYTM_STAT_W-1:0]);

  wire logic [`CYTM_IEN_W-1:0] ien_nxt;

  // Enable bits above the status width are kept so software reads back what it wrote.
  assign ien_nxt = (wr_en & sel_ien) ? pwdata[`CYTM_IEN_W-1:0] : ien_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE14: enables cleared.
      ien_r <= `CYTM_IEN_RST;
    end else begin
      ien_r <= ien_nxt;
    end
  end

  // The pin level is stored inverted, so no gate sits between the flop and the pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_r <= 1'b1;
    end else begin
      // RULE21: level interrupt.
      irq_n_r <= ~irq_nxt;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cycle_master = ctrl_r[`CYTM_CTRL_MASTER];
  assign irq_n = irq_n_r;

endmodule // cytm_events

// ===== cytm_events_sva.sv
// Concurrent checks on the ports of the cycle timer block.
// Assumes one pclk domain and the constants header in the include path.
`timescale 1ns/1ns
`include "cytm_defs.svh"

module cytm_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cytm_pkg::cytm_evt_t evt,
  input wire logic cycle_master,
  input wire logic irq_n
);
  import cytm_pkg::*;
  // ****************************************
  // Bus and event properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  wire logic rd_ok = pready && !pwrite && !pslverr;
  wire logic mapped = paddr == `CYTM_OFS_CTRL || paddr == `CYTM_OFS_STAT ||
    paddr == `CYTM_OFS_IEN || paddr == `CYTM_OFS_TIME;
  a_ready_after_setup: assert property (setup |=> pready && penable)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata not zero outside access");
  a_slverr_unmapped: assert property (setup && !mapped |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  a_slverr_mapped: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_master_clear_write: assert property (pready && psel && penable && pwrite &&
    paddr == `CYTM_OFS_CTRL && !pwdata[1] |=> !cycle_master)
    else $error("cycle master not cleared by write");
  a_ien_upper_zero: assert property (rd_ok && paddr == `CYTM_OFS_IEN |->
    prdata[31:22] == 10'h0)
    else $error("enable register upper bits not zero");
  a_stat_upper_zero: assert property (rd_ok && paddr == `CYTM_OFS_STAT |->
    prdata[31:9] == 23'h0)
    else $error("status register upper bits not zero");
  a_reset_quiet_out: assert property ($rose(presetn) |-> irq_n && !cycle_master && !pready)
    else $error("outputs active right after reset");
  a_master_host_set: assert property ($rose(cycle_master) |-> $past(psel && penable && pready &&
    pwrite && paddr == `CYTM_OFS_CTRL && pwdata[1]))
    else $error("cycle master rose without a host write");
  c_cycle_start: cover property (evt.cycle_start_tx);
  c_irq_active: cover property (!irq_n);
  c_unmapped: cover property (pslverr);
  c_master_drop: cover property ($fell(cycle_master));
endmodule // cytm_chk

bind cytm_events cytm_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .evt(evt), .cycle_master(cycle_master), .irq_n(irq_n));

// ===== cytm_host_model.sv
// Host processor model: an APB master with word read and write tasks.
// Assumes tasks are called right after a rising pclk edge.
`timescale 1ns/1ns

module cytm_host_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // One idle edge first, so a strobe is never assigned twice in a time step.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h00000000, q);
  endtask
endmodule // cytm_host_model

// ===== cytm_pkg.sv
// Types shared by the cycle timer block and its surroundings.
// Assumes the constants header is compiled alongside.
package cytm_pkg;

  // Same-clock event strobes from the link's transmitter and receiver.
  typedef struct packed {
    logic busy_ack_sent;
    logic header_crc_error;
    logic bad_transaction_code;
    logic cycle_start_tx;
    logic cycle_start_rx;
    logic fair_gap;
  } cytm_evt_t;

  typedef struct packed {
    logic [6:0] seconds;
    logic [12:0] number;
    logic [11:0] offset;
  } cytm_time_t;

  typedef enum logic {
    CYTM_IDLE = 1'b0,
    CYTM_RUN = 1'b1
  } cytm_phase_t;

endpackage
